// File: sar_adc_map.svh
// Register offsets, field positions, reset values and timing counts of the ADC sequencer
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH
// Register byte offsets
`define ADC_CTRL_OFS 12'h000
`define ADC_CFG_OFS 12'h004
`define ADC_PINS_OFS 12'h008
`define ADC_RES_OFS 12'h00c
`define ADC_STAT_OFS 12'h010
`define ADC_MASK_OFS 12'h014
// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_START_BIT 1
`define CTRL_IRQEN_BIT 2
`define CTRL_GIE_BIT 3
// Configuration register fields
`define CFG_DIV_LSB 0
`define CFG_SW_LSB 2
`define CFG_RES_LSB 4
`define CFG_VHS_LSB 6
`define CFG_EXTREF_BIT 8
`define CFG_CHS_LSB 9
`define CFG_GLOBAL_CHANNEL_SELECT_BIT 13
// Status fields
`define STAT_EOC_BIT 0
`define STAT_BUSY_BIT 1
// Reset values
`define CFG_RST 14'h0000
`define PINS_RST 16'h0000
`define MASK_RST 1'h1
// Timing: fixed phases besides sampling and bit decisions
`define CONV_EXTRA_CLKS 4'h2
`endif

// File: sar_adc_pkg.sv
// Types shared by the ADC sequencer files
`default_nettype none
package sar_adc_pkg;
	typedef enum logic [1:0] {IDLE, SAMPLE, CONVERT, FINISH} seq_state_t;
endpackage
`default_nettype wire

// File: conv_clock_gen.sv
// Converter clock tick generator dividing the CPU clock
`include "sar_adc_map.svh"
`default_nettype none
module conv_clock_gen (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	// Control
	input wire logic run,
	input wire logic [1:0] divSel,
	// Tick out
	output logic tick
);
	typedef struct packed {
		logic [3:0] cnt;
	} div_state_t;
	div_state_t s_r, s_nxt;
	logic [3:0] lim;
	// Divide ratio decode, 00:16 01:8 10:1 11:2
	always_comb
	begin
		case (divSel)
			2'h0: lim = 4'hf;
			2'h1: lim = 4'h7;
			2'h2: lim = 4'h0;
			default: lim = 4'h1;
		endcase
		s_nxt = s_r;
		if (!run)
			s_nxt.cnt = 4'h0;
		else if (s_r.cnt >= lim)
			s_nxt.cnt = 4'h0;
		else
			s_nxt.cnt = s_r.cnt + 4'h1;
	end
	assign tick = run && (s_r.cnt >= lim);
	// State register
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			s_r <= '0;
		else if (clkEn)
			s_r <= s_nxt;
	end
endmodule
`default_nettype wire

// File: sar_adc_sequencer.sv
// SAR ADC control, sequencing and APB register file
`include "sar_adc_map.svh"
`default_nettype none
module sar_adc_sequencer (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic clkEn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog front end
	input wire logic compOut,
	output logic sampleHold,
	output logic [11:0] dacCode,
	output logic converterEnable,
	output logic refExternal,
	output logic [1:0] refInternal,
	output logic [12:0] muxSelect,
	// Pin analog mode
	output logic [15:0] digInDisable,
	// Interrupt
	output logic irq
);
	typedef struct packed {
		sar_adc_pkg::seq_state_t st;
		logic en;
		logic irqEn;
		logic global_irq_enable;
		logic [13:0] cfg;
		logic [15:0] pins;
		logic [11:0] sar;
		logic [11:0] res;
		logic [3:0] bitIdx;
		logic [3:0] cnt;
		logic eoc;
		logic stat;
		logic mask;
		logic [31:0] rdata;
	} adc_state_t;
	adc_state_t s_r, s_nxt;
	logic tick;
	logic wrAcc, rdAcc;
	logic [3:0] swClks;
	logic [3:0] nBits;
	logic [11:0] resAligned;
	logic eocRise;
	// Comparator settles in-cycle from the registered trial code, so it is read directly;
	// a two-flop delay would judge stale trial codes at divide by one and two
	// converter clock divider
	conv_clock_gen conv_clock_gen_inst (
		.mclk(mclk),
		.rst(rst),
		.clkEn(clkEn),
		.run(s_r.en),
		.divSel(s_r.cfg[`CFG_DIV_LSB +: 2]),
		.tick(tick)
	);
	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	always_comb
	begin
		case (s_r.cfg[`CFG_SW_LSB +: 2])
			2'h0: swClks = 4'h1;
			2'h1: swClks = 4'h2;
			2'h2: swClks = 4'h4;
			default: swClks = 4'h8;
		endcase
		case (s_r.cfg[`CFG_RES_LSB +: 2])
			2'h0: nBits = 4'h8;
			2'h1: nBits = 4'ha;
			default: nBits = 4'hc;
		endcase
	end
	assign wrAcc = psel && penable && pwrite;
	assign rdAcc = psel && penable && !pwrite;
	assign eocRise = s_nxt.eoc && !s_r.eoc;
	// Result right-aligned to the chosen bit count
	assign resAligned = s_r.sar >> (4'hc - nBits);
	// ------------------------------------------------------------
	// Sequencer and registers
	// ------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		// Register writes
		if (wrAcc)
		begin
			case (paddr)
				`ADC_CTRL_OFS:
				begin
					s_nxt.en = pwdata[`CTRL_EN_BIT];
					s_nxt.irqEn = pwdata[`CTRL_IRQEN_BIT];
					s_nxt.global_irq_enable = pwdata[`CTRL_GIE_BIT];
				end
				`ADC_CFG_OFS: s_nxt.cfg = pwdata[13:0];
				`ADC_PINS_OFS: s_nxt.pins = pwdata[15:0];
				`ADC_MASK_OFS: s_nxt.mask = pwdata[0];
				default: s_nxt.en = s_nxt.en;
			endcase
		end
		// Read of status clears sticky bit
		if (rdAcc && paddr == `ADC_STAT_OFS)
			s_nxt.stat = 1'b0;
		case (s_r.st)
			sar_adc_pkg::IDLE:
			begin
				if (wrAcc && paddr == `ADC_CTRL_OFS && pwdata[`CTRL_START_BIT]
					&& pwdata[`CTRL_EN_BIT] && s_r.en)
				begin
					s_nxt.eoc = 1'b0;
					s_nxt.cnt = 4'h0;
					s_nxt.sar = 12'h800;
					s_nxt.bitIdx = 4'hb;
					s_nxt.st = sar_adc_pkg::SAMPLE;
				end
			end
			sar_adc_pkg::SAMPLE:
			begin
				if (tick)
				begin
					if (s_r.cnt == swClks - 4'h1)
					begin
						s_nxt.cnt = 4'h0;
						s_nxt.st = sar_adc_pkg::CONVERT;
					end
					else
						s_nxt.cnt = s_r.cnt + 4'h1;
				end
			end
			sar_adc_pkg::CONVERT:
			begin
				if (tick)
				begin
					if (!compOut)
						s_nxt.sar[s_r.bitIdx] = 1'b0;
					if (s_r.cnt == nBits - 4'h1)
					begin
						s_nxt.cnt = 4'h0;
						s_nxt.st = sar_adc_pkg::FINISH;
					end
					else
					begin
						s_nxt.cnt = s_r.cnt + 4'h1;
						s_nxt.bitIdx = s_r.bitIdx - 4'h1;
						s_nxt.sar[s_r.bitIdx - 4'h1] = 1'b1;
					end
				end
			end
			sar_adc_pkg::FINISH:
			begin
				if (tick)
				begin
					if (s_r.cnt == `CONV_EXTRA_CLKS - 4'h1)
					begin
						s_nxt.eoc = 1'b1;
						s_nxt.st = sar_adc_pkg::IDLE;
					end
					else
						s_nxt.cnt = s_r.cnt + 4'h1;
				end
			end
			default: s_nxt.st = sar_adc_pkg::IDLE;
		endcase
		if (!s_nxt.en)
			s_nxt.st = sar_adc_pkg::IDLE;
		// latch result at end flag rise
		if (s_nxt.eoc && !s_r.eoc)
			s_nxt.res = resAligned;
		// interrupt event on rise, set wins over clear
		if (s_nxt.eoc && !s_r.eoc && s_r.irqEn && s_r.global_irq_enable)
			s_nxt.stat = 1'b1;
		// Read data captured at setup
		s_nxt.rdata = 32'h0;
		case (paddr)
			`ADC_CTRL_OFS: s_nxt.rdata = {28'h0, s_r.global_irq_enable, s_r.irqEn,
				s_r.st != sar_adc_pkg::IDLE, s_r.en};
			`ADC_CFG_OFS: s_nxt.rdata = {18'h0, s_r.cfg};
			`ADC_PINS_OFS: s_nxt.rdata = {16'h0, s_r.pins};
			`ADC_RES_OFS: s_nxt.rdata = {20'h0, s_r.res};
			`ADC_STAT_OFS: s_nxt.rdata = {29'h0, s_r.stat,
				s_r.st != sar_adc_pkg::IDLE, s_r.eoc};
			`ADC_MASK_OFS: s_nxt.rdata = {31'h0, s_r.mask};
			default: s_nxt.rdata = 32'h0;
		endcase
	end
	// State register
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_r <= '0;
			s_r.cfg <= `CFG_RST;
			s_r.pins <= `PINS_RST;
			s_r.mask <= `MASK_RST;
			s_r.eoc <= 1'b1;
		end
		else if (clkEn)
			s_r <= s_nxt;
	end
	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// APB answers with no wait state, slverr on unmapped address
	assign pready = 1'b1;
	assign prdata = s_r.rdata;
	assign pslverr = psel && penable && (paddr > `ADC_MASK_OFS || paddr[1:0] != 2'h0);
	assign sampleHold = (s_r.st == sar_adc_pkg::SAMPLE);
	assign dacCode = s_r.sar;
	assign converterEnable = s_r.en;
	assign refExternal = s_r.cfg[`CFG_EXTREF_BIT];
	assign refInternal = s_r.cfg[`CFG_VHS_LSB +: 2];
	assign digInDisable = s_r.pins;
	// one-hot mux select, none when global select low
	genvar gi;
	generate
		for (gi = 0; gi < 13; gi++)
		begin : g_mux
			assign muxSelect[gi] = s_r.cfg[`CFG_GLOBAL_CHANNEL_SELECT_BIT]
				&& (s_r.cfg[`CFG_CHS_LSB +: 4] == 4'(gi));
		end
	endgenerate
	assign irq = s_r.stat && s_r.mask;
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_eoc_low_busy;
		@(posedge mclk) disable iff (rst)
		(s_r.st != sar_adc_pkg::IDLE) |-> !s_r.eoc;
	endproperty
	a_eoc_low_busy: assert property (p_eoc_low_busy)
		else $error("end flag high while busy");
	property p_irq_on_rise;
		@(posedge mclk) disable iff (rst)
		(clkEn && eocRise && s_r.irqEn && s_r.global_irq_enable) |=> s_r.stat;
	endproperty
	a_irq_on_rise: assert property (p_irq_on_rise)
		else $error("interrupt not set on end flag rise");
	property p_no_irq_disabled;
		@(posedge mclk) disable iff (rst)
		(clkEn && eocRise && !s_r.global_irq_enable && !s_r.stat) |=> !s_r.stat;
	endproperty
	a_no_irq_disabled: assert property (p_no_irq_disabled)
		else $error("interrupt set while globally disabled");
	property p_result_latch;
		@(posedge mclk) disable iff (rst)
		(clkEn && eocRise) |=> (s_r.res == $past(resAligned));
	endproperty
	a_result_latch: assert property (p_result_latch)
		else $error("result not latched");
	property p_idle_when_off;
		@(posedge mclk) disable iff (rst)
		!s_r.en |-> (s_r.st == sar_adc_pkg::IDLE);
	endproperty
	a_idle_when_off: assert property (p_idle_when_off)
		else $error("converting while disabled");
	property p_mux_off;
		@(posedge mclk) disable iff (rst)
		!s_r.cfg[`CFG_GLOBAL_CHANNEL_SELECT_BIT] |-> (muxSelect == 13'h0);
	endproperty
	a_mux_off: assert property (p_mux_off)
		else $error("mux connected without global select");
	property p_div1_tick;
		@(posedge mclk) disable iff (rst)
		(s_r.en && s_r.cfg[`CFG_DIV_LSB +: 2] == 2'h2 && $stable(s_r.cfg)) |-> tick;
	endproperty
	a_div1_tick: assert property (p_div1_tick)
		else $error("divide by one missing tick");
	property p_sample_len;
		@(posedge mclk) disable iff (rst)
		(clkEn && s_r.st == sar_adc_pkg::SAMPLE && s_r.cnt < swClks - 4'h1 && tick)
		|=> (s_r.st == sar_adc_pkg::SAMPLE) || !s_r.en;
	endproperty
	a_sample_len: assert property (p_sample_len)
		else $error("sampling ended early");
endmodule
`default_nettype wire

// File: sar_analog_model.sv
// Behavioural analog front end: sample-and-hold and comparator
`default_nettype none
module sar_analog_model (
	// Clock
	input wire logic mclk,
	// Sequencer side
	input wire logic sampleHold,
	input wire logic converterEnable,
	input wire logic [12:0] muxSelect,
	input wire logic [11:0] dacCode,
	// Source level and decision
	input wire logic [11:0] vin,
	output logic compOut
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] held_r = 12'h000;
	// Track the source while sampling, hold it afterwards
	always_ff @(posedge mclk)
		if (sampleHold)
			held_r <= vin;
	assign compOut = converterEnable && (|muxSelect) && (held_r >= dacCode);
endmodule
`default_nettype wire

// File: sar_adc_sequencer_test.sv
// Self-checking bench for the ADC sequencer over APB
`include "sar_adc_map.svh"
`default_nettype none
module sar_adc_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIAS_CYCLES = 25600;
	logic mclk = 0, rst = 1, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000, vin = 12'h000, dacCode;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, compOut, sampleHold, converterEnable, refExternal, irq, lastErr;
	logic [1:0] refInternal;
	logic [12:0] muxSelect;
	logic [15:0] digInDisable;
	int failCount = 0, testsRun = 0, cyc = 0, shW = 0;
	int dc[4] = '{0, 2, 3, 1};
	int sc[4] = '{3, 0, 1, 2};
	int rc[4] = '{2, 3, 1, 0};
	int dv[4] = '{16, 8, 1, 2};
	int sv[4] = '{1, 2, 4, 8};
	int bv[4] = '{8, 10, 12, 12};
	logic [11:0] vins[4] = '{12'h800, 12'h5a3, 12'hfff, 12'h000};

	sar_adc_sequencer sar_adc_sequencer_inst (.mclk, .rst, .clkEn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .compOut, .sampleHold, .dacCode,
		.converterEnable, .refExternal, .refInternal, .muxSelect, .digInDisable, .irq);
	sar_analog_model sar_analog_model_inst (.mclk, .sampleHold, .converterEnable,
		.muxSelect, .dacCode, .vin, .compOut);

	// Clock
	always #5 mclk = ~mclk;
	// Cycle and sampling-width counters
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (sampleHold === 1)
			shW <= shW + 1;
	end

	// -----------------------------
	// Access and compare tasks
	// -----------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			failCount++;
		end
	endtask
	// One APB transfer: setup, access until pready, then one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1;
		do
			@(posedge mclk);
		while (pready !== 1);
		rd = prdata;
		lastErr = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge mclk);
	endtask
	task automatic rdChk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 32'h00000000);
		chk(what, exp, rd);
	endtask
	// One conversion with timing, result and status checks
	task automatic conv(input int k, input logic [31:0] ctrl, input logic ie, input logic [31:0] st);
		int d, t, s, c0, s0, e;
		d = dv[dc[k]];
		s = sv[sc[k]];
		t = s + bv[rc[k]] + 2;
		vin <= vins[k];
		apb(1, `ADC_CFG_OFS, 32'h2000 | (rc[k] << 4) | (sc[k] << 2) | dc[k]);
		c0 = cyc;
		s0 = shW;
		apb(1, `ADC_CTRL_OFS, ctrl | 32'h2);
		apb(1, `ADC_CTRL_OFS, ctrl | 32'h2);
		rdChk("busyStat", `ADC_STAT_OFS, 32'h2);
		while (irq !== 1 && cyc - c0 < 2 * t * d + 8)
			@(posedge mclk);
		e = cyc - c0 - 2;
		chk("irq", ie, irq);
		if (ie)
			chk("convTime", 1, e >= (t - 1) * d + 2 && e <= t * d + 1);
		chk("sampleLen", 1, shW - s0 >= (s - 1) * d + 1 && shW - s0 <= s * d);
		rdChk("result", `ADC_RES_OFS, vins[k] >> (12 - bv[rc[k]]));
		rdChk("doneStat", `ADC_STAT_OFS, st);
		chk("irqCleared", 0, irq);
	endtask
	// Verdict and end of run
	task automatic wrapUp;
		$display("checks %0d mismatches %0d", testsRun, failCount);
		if (failCount == 0 && testsRun > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// -----------------------------
	// Test sequence
	// -----------------------------
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		rdChk("ctrlRst", `ADC_CTRL_OFS, 32'h0);
		rdChk("cfgRst", `ADC_CFG_OFS, 32'h0);
		rdChk("pinsRst", `ADC_PINS_OFS, 32'h0);
		rdChk("maskRst", `ADC_MASK_OFS, 32'h1);
		rdChk("statRst", `ADC_STAT_OFS, 32'h1);
		apb(0, 12'h018, 32'h0);
		chk("slvErr", 1, lastErr);
		chk("unmapped", 0, rd);
		$display("test reset done");
		for (int c = 0; c < 16; c++)
		begin
			apb(1, `ADC_CFG_OFS, 32'h2000 | (c << 9) | ((c & 1) << 8) | ((c & 3) << 6));
			chk("mux", c < 13 ? 32'h1 << c : 32'h0, muxSelect);
			chk("refExt", c & 1, refExternal);
			chk("refInt", c & 3, refInternal);
		end
		apb(1, `ADC_CFG_OFS, 32'hc << 9);
		chk("muxOff", 0, muxSelect);
		apb(1, `ADC_PINS_OFS, 32'ha5c3);
		chk("analogPins", 32'ha5c3, digInDisable);
		rdChk("pinsBack", `ADC_PINS_OFS, 32'ha5c3);
		clkEn <= 0;
		apb(1, `ADC_PINS_OFS, 32'h0000);
		clkEn <= 1;
		chk("frozenPins", 32'ha5c3, digInDisable);
		$display("test config done");
		apb(1, `ADC_CTRL_OFS, 32'hd);
		repeat (BIAS_CYCLES) @(posedge mclk);
		chk("enable", 1, converterEnable);
		for (int k = 0; k < 4; k++)
			conv(k, 32'hd, 1, 32'h5);
		apb(1, `ADC_MASK_OFS, 32'h0);
		conv(1, 32'hd, 0, 32'h5);
		apb(1, `ADC_MASK_OFS, 32'h1);
		conv(1, 32'h5, 0, 32'h1);
		$display("test conversions done");
		apb(1, `ADC_CTRL_OFS, 32'h2);
		repeat (40) @(posedge mclk);
		chk("enableOff", 0, converterEnable);
		rdChk("noStart", `ADC_STAT_OFS, 32'h1);
		$display("test disabled start done");
		wrapUp();
	end

	// Watchdog against a hung handshake or conversion
	initial
	begin
		repeat (60000) @(posedge mclk);
		failCount++;
		$display("watchdog expired");
		wrapUp();
	end
endmodule
`default_nettype wire
